/* File: core/cfr_pkg.sv */
// constants, field layouts and carrier types of the fault response block
package cfr_pkg;

  // clock and derived cycle counts
  localparam int CLK_HZ          = 50_000_000;
  localparam int CAL_SHOW_S      = 2;
  localparam int CAL_SHOW_CYC    = CAL_SHOW_S * CLK_HZ;
  localparam int BLINK_MS        = 500;
  localparam int BLINK_CYC       = BLINK_MS * (CLK_HZ / 1000);
  localparam int LBA_TICK_MS     = 1;
  localparam int LBA_TICK_CYC    = LBA_TICK_MS * (CLK_HZ / 1000);
  localparam int MOTOR_STEP_MS   = 100;
  localparam int MOTOR_STEP_CYC  = MOTOR_STEP_MS * (CLK_HZ / 1000);
  localparam int CNT_W           = 27;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_AUX    = 8'h04;
  localparam logic [7:0] REG_FLTMV  = 8'h08;
  localparam logic [7:0] REG_LBA    = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK   = 8'h14;
  localparam logic [7:0] REG_STATE  = 8'h18;

  // reset values
  localparam logic [10:0] CTRL_RST  = 11'h040;
  localparam logic [3:0]  AUX_RST   = 4'h0;
  localparam logic [9:0]  FLTMV_RST = 10'h000;
  localparam logic [15:0] LBA_RST   = 16'h0000;
  localparam logic [6:0]  MASK_RST  = 7'h00;

  // manipulated value scale in 0.1 %
  localparam logic [9:0]  MV_ZERO   = 10'h000;
  localparam logic [9:0]  MV_FULL   = 10'h3e8;
  localparam logic [15:0] LBA_BAND  = 16'h0002;
  localparam logic signed [15:0] PV_LOW  = -16'sd1999;
  localparam logic signed [15:0] PV_HIGH = 16'sd9999;
  localparam int ALARM_N = 3;

  // error codes shown on the main display
  localparam logic [3:0] CODE_NONE           = 4'h0;
  localparam logic [3:0] CODE_INPUT          = 4'h1;
  localparam logic [3:0] CODE_MEMORY         = 4'h2;
  localparam logic [3:0] converter_fault_code = 4'h3;
  localparam logic [3:0] CODE_CAL            = 4'h4;

  // status bit positions
  localparam int ST_INPUT = 0;
  localparam int ST_MEM   = 1;
  localparam int ST_ADC   = 2;
  localparam int ST_RSP   = 3;
  localparam int ST_LBA   = 4;
  localparam int ST_MERR  = 5;
  localparam int ST_MDONE = 6;

  // auxiliary output assignment codes
  localparam logic [1:0] AUX_NONE = 2'h0;
  localparam logic [1:0] AUX_ERR1 = 2'h1;
  localparam logic [1:0] AUX_ERR2 = 2'h2;
  localparam logic [1:0] AUX_ERR3 = 2'h3;

  typedef enum logic [1:0] {
    MODE_STD = 2'h0, MODE_HEATCOOL = 2'h1, MODE_POSPROP = 2'h2, MODE_ONOFF = 2'h3
  } cfr_mode_t;

  typedef enum logic [3:0] {
    MOT_IDLE = 4'b0001, MOT_OPEN = 4'b0010, MOT_CLOSE = 4'b0100, MOT_CHECK = 4'b1000
  } cfr_mot_t;

  typedef struct packed {
    logic      motor_go;
    logic      at_reduced_sel;
    logic      at_req;
    logic      st_en;
    logic      run;
    logic      rsp_en;
    logic      cur_out;
    cfr_mode_t mode;
    logic [1:0] input_kind;
  } cfr_ctrl_t;

  typedef struct packed {
    logic sensor;
    logic mem;
    logic adc;
    logic cal_bad;
    logic rsp;
    logic rsp_broken;
    logic fb_ok;
  } cfr_pins_t;

  typedef struct packed {
    logic               show_code;
    logic [3:0]         err_code;
    logic [9:0]         mv_out;
    logic               mv_off;
    logic               cur_low;
    logic [ALARM_N-1:0] alarm;
    logic [1:0]         aux;
    logic               under;
    logic               over;
    logic               cal_show;
    logic               rsp_blink;
    logic               loop_break_alarm;
    logic               self_tuning;
    logic               auto_tuning;
    logic               reduced_swing_autotune;
    logic               limit_bypass;
    logic               ramp_bypass;
    logic               mot_open;
    logic               mot_close;
    logic               mot_err;
  } cfr_out_t;

  typedef struct packed {
    cfr_pins_t        s1;
    cfr_pins_t        s2;
    logic             mem_lat;
    logic             adc_lat;
    cfr_ctrl_t        ctrl;
    logic [3:0]       aux_sel;
    logic [9:0]       fault_mv;
    logic [15:0]      lba_time;
    logic [6:0]       status;
    logic [6:0]       mask;
    logic [CNT_W-1:0] blink_cnt;
    logic             blink;
    logic [CNT_W-1:0] cal_cnt;
    logic [15:0]      lba_tick;
    logic [15:0]      lba_cnt;
    logic [15:0]      lba_ref;
    logic             lba_hit;
    cfr_mot_t         mot;
    logic [CNT_W-1:0] mot_cnt;
    logic             mot_done;
    logic             mot_fail;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             irq;
    cfr_out_t         out;
  } cfr_state_t;

endpackage

/* File: core/cfr_fault_response.sv */
// fault detection, fault response, error outputs and tuning interlocks
`timescale 1ns/1ns

module cfr_fault_response #(
  parameter int CAL_SHOW_CYCLES   = cfr_pkg::CAL_SHOW_CYC,
  parameter int BLINK_CYCLES      = cfr_pkg::BLINK_CYC,
  parameter int LBA_TICK_CYCLES   = cfr_pkg::LBA_TICK_CYC,
  parameter int MOTOR_STEP_CYCLES = cfr_pkg::MOTOR_STEP_CYC
) (
  // clock and reset
  input  logic                       mclk,
  input  logic                       reset,
  // apb slave
  input  logic                       psel,
  input  logic                       penable,
  input  logic                       pwrite,
  input  logic [7:0]                 paddr,
  input  logic [31:0]                pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // fault pins, asynchronous
  input  cfr_pkg::cfr_pins_t         fault_pins,
  // control path, same clock
  input  logic signed [15:0]         process_value,
  input  logic [9:0]                 mv_calc,
  input  logic [cfr_pkg::ALARM_N-1:0] alarm_req,
  // responses
  output cfr_pkg::cfr_out_t          ctl,
  output logic                       irq
);
  import cfr_pkg::*;

  cfr_state_t s;
  cfr_state_t next_s;

  logic             sens;
  logic             hard;
  logic             temp_in;
  logic             cal_win;
  logic             rsp_err;
  logic             st_run;
  logic             at_run;
  logic             sat;
  logic             access;
  logic             wr;
  logic [31:0]      rdat;
  logic             rerr;
  logic [6:0]       ev;
  logic [6:0]       w1c;
  logic [1:0]       sel;

  function automatic logic [15:0] pv_dist(input logic signed [15:0] a,
                                          input logic signed [15:0] b);
    logic signed [15:0] d;
    d = a - b;
    pv_dist = d[15] ? 16'(-d) : 16'(d);
  endfunction

  function automatic logic aux_level(input logic [1:0] code, input logic e1,
                                     input logic e2, input logic e3);
    case (code)
      AUX_ERR1: aux_level = e1;
      AUX_ERR2: aux_level = e2;
      AUX_ERR3: aux_level = e3;
      default:  aux_level = 1'b0;
    endcase
  endfunction

  always_comb
  begin
    next_s = s;
    // fault pins are asynchronous: two flops before use
    next_s.s1 = fault_pins;
    next_s.s2 = s.s1;

    // latched until reset; a fault still present afterwards re-latches
    next_s.mem_lat = s.mem_lat | s.s2.mem;
    next_s.adc_lat = s.adc_lat | s.s2.adc;
    hard = s.mem_lat | s.adc_lat;
    sens = s.s2.sensor;
    temp_in = ~s.ctrl.input_kind[1];
    rsp_err = s.ctrl.rsp_en & s.s2.rsp;

    // display alternation timebase
    if (s.blink_cnt == CNT_W'(BLINK_CYCLES - 1))
    begin
      next_s.blink_cnt = '0;
      next_s.blink = ~s.blink;
    end
    else
    begin
      next_s.blink_cnt = s.blink_cnt + 1'b1;
    end

    // power-on window for the calibration indication
    cal_win = s.cal_cnt != CNT_W'(CAL_SHOW_CYCLES);
    if (cal_win)
    begin
      next_s.cal_cnt = s.cal_cnt + 1'b1;
    end

    // loop break: output saturated while the process value stays put
    sat = (mv_calc == MV_ZERO) | (mv_calc >= MV_FULL);
    if (s.lba_tick == 16'(LBA_TICK_CYCLES - 1))
    begin
      next_s.lba_tick = '0;
      if (!sat || s.lba_time == '0 || !s.ctrl.run ||
          pv_dist(process_value, s.lba_ref) >= LBA_BAND)
      begin
        next_s.lba_cnt = '0;
        next_s.lba_ref = process_value;
        next_s.lba_hit = 1'b0;
      end
      else if (s.lba_cnt >= s.lba_time)
      begin
        next_s.lba_hit = 1'b1;
      end
      else
      begin
        next_s.lba_cnt = s.lba_cnt + 1'b1;
      end
    end
    else
    begin
      next_s.lba_tick = s.lba_tick + 1'b1;
    end

    // motor calibration sequence
    next_s.mot_done = 1'b0;
    case (s.mot)
      MOT_IDLE:
      begin
        next_s.mot_cnt = '0;
        if (s.ctrl.motor_go)
        begin
          next_s.mot_fail = 1'b0;
          next_s.mot = MOT_OPEN;
        end
      end
      MOT_OPEN:
      begin
        next_s.mot_cnt = s.mot_cnt + 1'b1;
        if (s.mot_cnt == CNT_W'(MOTOR_STEP_CYCLES - 1))
        begin
          next_s.mot_cnt = '0;
          next_s.mot = MOT_CLOSE;
        end
      end
      MOT_CLOSE:
      begin
        next_s.mot_cnt = s.mot_cnt + 1'b1;
        if (s.mot_cnt == CNT_W'(MOTOR_STEP_CYCLES - 1))
        begin
          next_s.mot_cnt = '0;
          next_s.mot = MOT_CHECK;
        end
      end
      MOT_CHECK:
      begin
        next_s.mot_fail = ~s.s2.fb_ok;
        next_s.mot_done = 1'b1;
        next_s.mot = MOT_IDLE;
      end
      default:
      begin
        next_s.mot = MOT_IDLE;
      end
    endcase

    // tuning interlocks
    st_run = s.ctrl.st_en & s.ctrl.run & ~s.ctrl.input_kind[1] &
             (s.ctrl.mode == MODE_STD);
    at_run = s.ctrl.at_req & s.ctrl.run & ~st_run &
             (s.ctrl.mode != MODE_ONOFF);

    // registered outputs
    next_s.out.self_tuning = st_run;
    next_s.out.auto_tuning = at_run;
    next_s.out.reduced_swing_autotune = at_run &
      (s.ctrl.at_reduced_sel | (s.ctrl.mode == MODE_HEATCOOL) |
       (s.ctrl.mode == MODE_POSPROP));
    next_s.out.limit_bypass = (s.ctrl.mode == MODE_ONOFF) | ~s.ctrl.run |
                              st_run;
    next_s.out.ramp_bypass = st_run;

    if (s.mem_lat)
      next_s.out.err_code = CODE_MEMORY;
    else if (s.adc_lat)
      next_s.out.err_code = converter_fault_code;
    else if (sens)
      next_s.out.err_code = CODE_INPUT;
    else if (s.s2.cal_bad && temp_in && cal_win)
      next_s.out.err_code = CODE_CAL;
    else
      next_s.out.err_code = CODE_NONE;
    next_s.out.cal_show = s.s2.cal_bad & temp_in & cal_win;
    next_s.out.show_code = (next_s.out.err_code != CODE_NONE) & s.blink;

    // calibration fault forces nothing: normal path stays in effect
    if (hard)
    begin
      next_s.out.mv_out = MV_ZERO;
      next_s.out.mv_off = 1'b1;
      next_s.out.cur_low = s.ctrl.cur_out;
      next_s.out.alarm = '0;
    end
    else if (sens)
    begin
      next_s.out.mv_out = s.fault_mv;
      next_s.out.mv_off = 1'b0;
      next_s.out.cur_low = 1'b0;
      next_s.out.alarm = '1;
    end
    else
    begin
      next_s.out.mv_out = mv_calc;
      next_s.out.mv_off = 1'b0;
      next_s.out.cur_low = 1'b0;
      next_s.out.alarm = alarm_req;
    end

    next_s.out.under = process_value < PV_LOW;
    next_s.out.over = process_value > PV_HIGH;
    next_s.out.rsp_blink = s.ctrl.rsp_en & s.s2.rsp_broken & s.blink;
    next_s.out.loop_break_alarm = s.lba_hit;
    next_s.out.mot_open = s.mot == MOT_OPEN;
    next_s.out.mot_close = s.mot == MOT_CLOSE;
    next_s.out.mot_err = s.mot_fail;
    for (int i = 0; i < 2; i++)
    begin
      sel = s.aux_sel[2*i +: 2];
      next_s.out.aux[i] = aux_level(sel, sens, s.adc_lat, rsp_err);
    end

    // apb: one wait state, pready from a flop
    access = psel & penable;
    wr = access & s.pready & pwrite;
    next_s.pready = access & ~s.pready;
    rerr = 1'b0;
    case (paddr)
      REG_CTRL:   rdat = 32'(s.ctrl);
      REG_AUX:    rdat = 32'(s.aux_sel);
      REG_FLTMV:  rdat = 32'(s.fault_mv);
      REG_LBA:    rdat = 32'(s.lba_time);
      REG_STATUS: rdat = 32'(s.status);
      REG_MASK:   rdat = 32'(s.mask);
      REG_STATE:  rdat = 32'({s.mot, s.lba_hit, cal_win, s.adc_lat, s.mem_lat, sens});
      default:
      begin
        rdat = '0;
        rerr = 1'b1;
      end
    endcase
    if (access && !s.pready)
    begin
      next_s.prdata = pwrite ? 32'h0000_0000 : rdat;
      next_s.pslverr = rerr;
    end
    else
    begin
      next_s.prdata = '0;
      next_s.pslverr = 1'b0;
    end

    // motor start is a one-shot
    next_s.ctrl.motor_go = 1'b0;
    w1c = '0;
    if (wr)
    begin
      case (paddr)
        REG_CTRL:   next_s.ctrl = cfr_ctrl_t'(pwdata[10:0]);
        REG_AUX:    next_s.aux_sel = pwdata[3:0];
        REG_FLTMV:  next_s.fault_mv = pwdata[9:0];
        REG_LBA:    next_s.lba_time = pwdata[15:0];
        REG_STATUS: w1c = pwdata[6:0];
        REG_MASK:   next_s.mask = pwdata[6:0];
        default:    w1c = '0;
      endcase
    end

    // sticky events: a set in the clearing cycle survives
    ev = '0;
    ev[ST_INPUT] = sens;
    ev[ST_MEM] = s.mem_lat;
    ev[ST_ADC] = s.adc_lat;
    ev[ST_RSP] = rsp_err;
    ev[ST_LBA] = s.lba_hit;
    ev[ST_MERR] = s.mot_done & s.mot_fail;
    ev[ST_MDONE] = s.mot_done;
    next_s.status = (s.status & ~w1c) | ev;
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s <= '0;
      s.ctrl <= cfr_ctrl_t'(CTRL_RST);
      s.aux_sel <= AUX_RST;
      s.fault_mv <= FLTMV_RST;
      s.lba_time <= LBA_RST;
      s.mask <= MASK_RST;
      s.mot <= MOT_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign ctl = s.out;
  assign irq = s.irq;
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;

endmodule // cfr_fault_response

/* File: testbench/cfr_checker.sv */
// concurrent checks on the fault response block ports
`timescale 1ns/1ns
module cfr_checker
  import cfr_pkg::*;
(
  // clock and reset
  input logic               mclk,
  input logic               reset,
  // apb
  input logic               psel,
  input logic               penable,
  input logic               pwrite,
  input logic [7:0]         paddr,
  input logic [31:0]        pwdata,
  input logic [31:0]        prdata,
  input logic               pready,
  input logic               pslverr,
  // plant side
  input cfr_pins_t          fault_pins,
  input logic signed [15:0] process_value,
  input logic [9:0]         mv_calc,
  input logic [ALARM_N-1:0] alarm_req,
  input cfr_out_t           ctl,
  input logic               irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  code_shown_a: assert property (ctl.show_code |-> ctl.err_code != CODE_NONE)
    else $error("code flashed with no error");
  sensor_alarms_a: assert property (ctl.err_code == CODE_INPUT |-> &ctl.alarm)
    else $error("alarms not forced on sensor fault");
  hard_off_a: assert property ((ctl.err_code == CODE_MEMORY || ctl.err_code ==
    converter_fault_code) |-> ctl.alarm == '0 && ctl.mv_out == MV_ZERO)
    else $error("outputs not off on hard fault");
  hard_latch_a: assert property (ctl.err_code == CODE_MEMORY |=> ctl.err_code == CODE_MEMORY
    && ctl.mv_off)
    else $error("memory fault not latched");
  range_flags_a: assert property (process_value < PV_LOW |=> ctl.under && !ctl.over)
    else $error("under-range flag missing");
  tune_lock_a: assert property (ctl.self_tuning |-> !ctl.auto_tuning && ctl.limit_bypass
    && ctl.ramp_bypass)
    else $error("self-tuning interlock broken");
  motor_order_a: assert property ($rose(ctl.mot_close) |-> $past(ctl.mot_open)
    && !ctl.mot_open)
    else $error("close drive not after open drive");
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer timing wrong");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
endmodule // cfr_checker

bind cfr_fault_response cfr_checker u_chk (.mclk(mclk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fault_pins(fault_pins),
  .process_value(process_value), .mv_calc(mv_calc), .alarm_req(alarm_req), .ctl(ctl),
  .irq(irq));

/* File: testbench/cfr_plant.sv */
// plant model: sensors, valve potentiometer and alarm sources
`timescale 1ns/1ns
module cfr_plant
  import cfr_pkg::*;
(
  // clock
  input  logic               mclk,
  // bench requests
  input  cfr_pins_t          fault_req,
  input  logic signed [15:0] pv_req,
  input  logic [9:0]         mv_req,
  input  logic [2:0]         alm_req,
  // device side
  input  cfr_out_t           ctl,
  output cfr_pins_t          fault_pins,
  output logic signed [15:0] process_value,
  output logic [9:0]         mv_calc,
  output logic [2:0]         alarm_req
);
  logic [7:0] pos = 8'h00;

  // the potentiometer only reads valid while the valve stands off its closed end (pos not zero)
  always @(posedge mclk)
  begin
    if (ctl.mot_open)
      pos <= pos + 8'h01;
    else if (ctl.mot_close && pos != 8'h00)
      pos <= pos - 8'h01;
    fault_pins       <= {fault_req[6:1], fault_req.fb_ok && pos != 8'h00};
    process_value    <= pv_req;
    mv_calc          <= mv_req;
    alarm_req        <= alm_req;
  end
endmodule // cfr_plant

/* File: testbench/test_cfr_fault_response.sv */
// self-checking bench for the fault response block
`timescale 1ns/1ns
module test_cfr_fault_response;
  import cfr_pkg::*;
  logic               mclk = 1'b0;
  logic               reset = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata, rdat;
  logic               pready, pslverr, irq, rerr;
  cfr_pins_t          fault_req = '0;
  cfr_pins_t          fault_pins;
  logic signed [15:0] pv_req = 16'sd100;
  logic signed [15:0] process_value;
  logic [9:0]         mv_req = 10'h1f4;
  logic [9:0]         mv_calc;
  logic [2:0]         alm_req = 3'h5;
  logic [2:0]         alarm_req;
  cfr_out_t           ctl;
  int                 mismatches = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  int                 n;
  logic [7:0]         ra[5] = '{REG_CTRL, REG_AUX, REG_FLTMV, REG_LBA, REG_MASK};
  logic [31:0]        rv[5] = '{32'(CTRL_RST), 32'(AUX_RST), 32'(FLTMV_RST), 32'(LBA_RST),
                                32'(MASK_RST)};

  always #10 mclk = ~mclk;

  cfr_fault_response #(.CAL_SHOW_CYCLES(50), .BLINK_CYCLES(4), .LBA_TICK_CYCLES(4),
    .MOTOR_STEP_CYCLES(8)) u_dut (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_pins(fault_pins),
    .process_value(process_value), .mv_calc(mv_calc), .alarm_req(alarm_req), .ctl(ctl),
    .irq(irq));

  cfr_plant u_plant (.mclk(mclk), .fault_req(fault_req), .pv_req(pv_req), .mv_req(mv_req),
    .alm_req(alm_req), .ctl(ctl), .fault_pins(fault_pins), .process_value(process_value),
    .mv_calc(mv_calc), .alarm_req(alarm_req));

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel in this time step
    @(posedge mclk);
  endtask

  task automatic final_report();
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      final_report();
    end
  end

  initial
  begin
    fault_req.cal_bad = 1'b1;
    tick(12);
    reset <= 1'b0;
    // pins need two sync edges plus the output flop, and reads here see pre-edge values
    tick(4);
    chk(ctl.cal_show, 1);
    chk(ctl.mv_out, mv_req);
    chk(ctl.alarm, alm_req);
    foreach (ra[i])
    begin
      apb(0, ra[i], 0);
      chk(rdat, rv[i]);
    end
    apb(0, 8'h1c, 0);
    chk(rerr, 1);
    chk(rdat, 0);
    fault_req.cal_bad <= 1'b0;
    tick(60);
    chk(ctl.cal_show, 0);
    // sensor fault: fault value, alarms, error output 1, interrupt
    apb(1, REG_FLTMV, 32'h123);
    apb(1, REG_AUX, 32'h9);
    apb(1, REG_MASK, 32'h1);
    fault_req.sensor <= 1'b1;
    tick(6);
    chk(ctl.mv_out, 10'h123);
    chk(ctl.alarm, 3'h7);
    chk(ctl.aux, 2'b01);
    chk(ctl.err_code, CODE_INPUT);
    chk(irq, 1);
    n = 0;
    repeat (16)
    begin
      tick(1);
      n += ctl.show_code;
    end
    chk(n > 0 && n < 16, 1);
    fault_req.sensor <= 1'b0;
    tick(6);
    apb(1, REG_STATUS, 32'h1);
    tick(2);
    chk({irq, ctl.aux}, 0);
    chk(ctl.mv_out, mv_req);
    // remote setpoint fault only counts while the function is enabled
    apb(1, REG_AUX, 32'hf);
    fault_req.rsp <= 1'b1;
    tick(5);
    chk(ctl.aux, 0);
    apb(1, REG_CTRL, 32'h060);
    tick(3);
    chk(ctl.aux, 2'b11);
    fault_req.rsp_broken <= 1'b1;
    n = 0;
    repeat (16)
    begin
      tick(1);
      n += ctl.rsp_blink;
    end
    chk(n > 0 && n < 16, 1);
    fault_req.rsp <= 1'b0;
    fault_req.rsp_broken <= 1'b0;
    pv_req <= -16'sd2000;
    tick(3);
    chk({ctl.under, ctl.over, ctl.err_code}, {2'b10, CODE_NONE});
    pv_req <= 16'sd10000;
    tick(3);
    chk({ctl.under, ctl.over, ctl.mv_out}, {2'b01, mv_req});
    pv_req <= 16'sd100;
    // every mode with self- and auto-tuning requested, last one stopped
    for (int m = 0; m < 5; m++)
    begin
      apb(1, REG_CTRL, (m < 4 ? 32'h1c0 : 32'h180) | 32'((m % 4) << 2));
      tick(3);
      chk(ctl.self_tuning, m == 0);
      chk({ctl.auto_tuning, ctl.reduced_swing_autotune}, {2{m == 1 || m == 2}});
      chk(ctl.limit_bypass, m != 1 && m != 2);
      chk(ctl.ramp_bypass, m == 0);
    end
    // analog input: self-tuning inhibited, auto-tuning still allowed
    apb(1, REG_CTRL, 32'h1c2);
    tick(3);
    chk({ctl.self_tuning, ctl.auto_tuning}, 2'b01);
    apb(1, REG_CTRL, 32'h440);
    for (int i = 0; i < 30 && ctl.mot_open !== 1'b1; i++) tick(1);
    chk({ctl.mot_open, ctl.mot_close}, 2'b10);
    for (int i = 0; i < 30 && ctl.mot_close !== 1'b1; i++) tick(1);
    chk({ctl.mot_open, ctl.mot_close}, 2'b01);
    for (int i = 0; i < 40 && ctl.mot_err !== 1'b1; i++) tick(1);
    chk(ctl.mot_err, 1);
    // output saturated with a frozen reading: loop break on the 4th four-cycle tick
    apb(1, REG_LBA, 32'h3);
    mv_req <= 10'h3e8;
    tick(2);
    chk(ctl.loop_break_alarm, 0);
    for (int i = 0; i < 200 && ctl.loop_break_alarm !== 1'b1; i++) tick(1);
    chk(ctl.loop_break_alarm, 1);
    apb(1, REG_LBA, 32'h0);
    mv_req <= 10'h1f4;
    // memory fault pulse stays latched and forces outputs off
    apb(1, REG_CTRL, 32'h050);
    fault_req.mem <= 1'b1;
    tick(5);
    fault_req.mem <= 1'b0;
    tick(5);
    chk(ctl.err_code, CODE_MEMORY);
    chk({ctl.mv_out, ctl.mv_off, ctl.cur_low, ctl.alarm}, {MV_ZERO, 2'b11, 3'h0});
    reset <= 1'b1;
    tick(12);
    reset <= 1'b0;
    tick(3);
    chk(ctl.err_code, CODE_NONE);
    apb(1, REG_AUX, 32'h9);
    fault_req.adc <= 1'b1;
    tick(5);
    fault_req.adc <= 1'b0;
    tick(5);
    chk(ctl.err_code, converter_fault_code);
    chk({ctl.aux, ctl.alarm, ctl.mv_out}, {2'b10, 3'h0, MV_ZERO});
    final_report();
  end
endmodule // test_cfr_fault_response
